//--- hw/pwr_params.svh
// register offsets, field positions and reset values of the power-mode controller
`ifndef PWR_PARAMS_SVH
`define PWR_PARAMS_SVH
`define OFS_PWR_CTRL 12'h000
`define OFS_PWR_STATUS 12'h004
`define OFS_PIN_ENABLE 12'h008
`define OFS_PERIPH_ENABLE 12'h00C
`define OFS_SLEEP_CFG 12'h010
`define OFS_BROWNOUT_CTRL 12'h014
`define OFS_WDT_MODE 12'h018
`define OFS_WAKE_PIN_EN 12'h01C
`define OFS_OSC_CTRL 12'h020
`define OFS_WAKE_TIMER 12'h024
`define OFS_NESTED_INTERRUPT_CTRL_EN 12'h028
`define OFS_GPREG0 12'h040
`define GPREG_NUM 5
`define WAKE_PIN_NUM 8
// pwr_ctrl fields
`define CTRL_MODE_LSB 0
`define CTRL_GO_BIT 4
`define CTRL_LOCK_BIT 5
// sleep_power_config fields
`define SCFG_BOD_BIT 0
`define SCFG_LPOSC_BIT 1
// brownout_control fields
`define BOD_INT_BIT 0
`define BOD_RST_BIT 1
// watchdog_mode_reg fields
`define WDT_EN_BIT 0
`define WDT_INT_BIT 1
`define WDT_RST_BIT 2
`define WDT_FEED_BIT 3
// periph enable bit positions
`define PER_BOD_BIT 0
`define PER_WDT_BIT 1
`define PER_WKT_BIT 2
`define PER_SER_BIT 3
// osc_ctrl fields
`define OSC_LPEN_BIT 0
`define OSC_LPSEL_BIT 1
`define OSC_WKTSEL_BIT 2
`define OSC_LPRDY_BIT 3
`define LPOSC_SETTLE_CYC 16'h0040
`define RST_SLEEP_CFG 32'h0000_0000
`endif

//--- hw/pwr_pkg.sv
// types of the power-mode controller
package pwr_pkg;
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_DEEP_SLEEP = 3'b010,
    MODE_POWER_DOWN = 3'b011,
    MODE_DEEP_PD = 3'b100
  } pwr_mode_t;
endpackage : pwr_pkg

//--- hw/wake_qualify.sv
// wake qualification per power mode
`timescale 1ns/1ps
`include "pwr_params.svh"
module wake_qualify
  import pwr_pkg::*;
(
  input wire pwr_mode_t mode,
  input wire logic [31:0] irq_pend,
  input wire logic [31:0] nested_interrupt_ctrl_en,
  input wire logic [7:0] pin_irq,
  input wire logic [7:0] pin_en,
  input wire logic [3:0] per_en,
  input wire logic [7:0] sleep_cfg,
  input wire logic [7:0] bod_ctrl,
  input wire logic [7:0] wdt_mode,
  input wire logic wdt_fed,
  input wire logic bod_int,
  input wire logic bod_rst,
  input wire logic wdt_int,
  input wire logic wkt_int,
  input wire logic wkt_lp_clk,
  input wire logic ser_int,
  input wire logic ser_slave_ext_clk,
  input wire logic [7:0] wake_pin_n,
  input wire logic [7:0] wake_pin_en,
  output logic wake,
  output logic wake_reset
);
  logic lp_ok;
  logic bod_ok;
  logic wdt_run;
  logic ds_wake;
  logic ds_rst;
  always_comb begin
    lp_ok = sleep_cfg[`SCFG_LPOSC_BIT];
    bod_ok = sleep_cfg[`SCFG_BOD_BIT];
    wdt_run = wdt_mode[`WDT_EN_BIT] & wdt_fed & lp_ok;
    ds_wake = |(pin_irq & pin_en & nested_interrupt_ctrl_en[7:0]);
    ds_wake = ds_wake | (bod_int & per_en[`PER_BOD_BIT] & nested_interrupt_ctrl_en[8]
              & bod_ctrl[`BOD_INT_BIT] & bod_ok);
    ds_wake = ds_wake | (wdt_int & per_en[`PER_WDT_BIT] & nested_interrupt_ctrl_en[9]
              & wdt_run & wdt_mode[`WDT_INT_BIT]);
    ds_wake = ds_wake | (wkt_int & per_en[`PER_WKT_BIT] & nested_interrupt_ctrl_en[10]
              & wkt_lp_clk);
    ds_wake = ds_wake | (ser_int & per_en[`PER_SER_BIT] & nested_interrupt_ctrl_en[11]
              & ser_slave_ext_clk);
    ds_rst = (bod_rst & bod_ctrl[`BOD_RST_BIT] & bod_ok)
             | (wdt_int & wdt_run & wdt_mode[`WDT_RST_BIT]);
    wake = 1'b0;
    wake_reset = 1'b0;
    unique case (mode)
      MODE_RUN: begin
        wake = 1'b0;
      end
      MODE_SLEEP: begin
        wake = |(irq_pend & nested_interrupt_ctrl_en);
      end
      MODE_DEEP_SLEEP, MODE_POWER_DOWN: begin
        wake = ds_wake;
        wake_reset = ds_rst;
      end
      MODE_DEEP_PD: begin
        wake = |(~wake_pin_n & wake_pin_en);
      end
      default: begin
        wake = 1'b0;
      end
    endcase
  end
endmodule : wake_qualify

//--- hw/pwr_mode_ctrl.sv
// power-mode controller with APB registers, retained storage and wake logic
// Function
// - deep power-down removes power from all but wake pin circuitry
// - any of eight wake pins ends deep power-down
// - five storage registers keep contents through deep power-down
// - set lock bit refuses deep power-down entry
// - per mode gating of oscillator, flash, peripherals and ADC
// - brownout and low-power osc configurable; wake pins wake only deep power-down
// - in sleep any NESTED_INTERRUPT_CTRL-enabled interrupt wakes the core
// - pin wake needs NESTED_INTERRUPT_CTRL and start logic pin enable
// - brownout interrupt wake needs three enables and detector powered
// - brownout reset wake needs reset enable and detector powered
// - watchdog interrupt wake needs running, fed watchdog and enables
// - watchdog reset wake needs running watchdog with reset enabled
// - self-wake timer needs enables, low-power clock; count write starts it
// - serial wake needs interrupt enable, slave mode, external clock
// - wake pin acts only when enabled in wake pin enable register
// - power-up runs from free-running osc; switch after low-power osc settles
// - sleep stops core clock; peripherals keep running
`timescale 1ns/1ps
`include "pwr_params.svh"
module pwr_mode_ctrl
  import pwr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] irq_pend,
  input wire logic [7:0] pin_irq,
  input wire logic bod_int,
  input wire logic bod_rst,
  input wire logic wdt_int,
  input wire logic wkt_int,
  input wire logic ser_int,
  input wire logic ser_slave_ext_clk,
  input wire logic lposc_ready,
  input wire logic [7:0] wake_pin_n,
  output logic core_clk_en,
  output logic fro_on,
  output logic fro_out_en,
  output logic flash_on,
  output logic flash_standby,
  output logic periph_on,
  output logic adc_on,
  output logic bod_on,
  output logic lposc_on,
  output logic main_pwr_on,
  output logic wake_reset_req,
  output logic clk_sel_lposc,
  output logic [31:0] wkt_count
);
  typedef struct packed {
    pwr_mode_t mode;
    logic lock;
    logic [7:0] pin_en;
    logic [3:0] per_en;
    logic [7:0] sleep_cfg;
    logic [7:0] bod_ctrl;
    logic [7:0] wdt_mode;
    logic wdt_fed;
    logic [7:0] wake_pin_en;
    logic lp_en;
    logic lp_sel;
    logic wkt_sel;
    logic [31:0] wkt_cnt;
    logic [31:0] nested_interrupt_ctrl_en;
    logic [`GPREG_NUM*32-1:0] gpreg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_clk_en;
    logic fro_on;
    logic fro_out_en;
    logic flash_on;
    logic flash_standby;
    logic periph_on;
    logic adc_on;
    logic bod_on;
    logic lposc_on;
    logic main_pwr_on;
    logic wake_rst;
    logic dpd_woken;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic wake;
  logic wake_reset;
  logic setup;

  wake_qualify u_wake (
    .mode(st_r.mode),
    .irq_pend(irq_pend),
    .nested_interrupt_ctrl_en(st_r.nested_interrupt_ctrl_en),
    .pin_irq(pin_irq),
    .pin_en(st_r.pin_en),
    .per_en(st_r.per_en),
    .sleep_cfg(st_r.sleep_cfg),
    .bod_ctrl(st_r.bod_ctrl),
    .wdt_mode(st_r.wdt_mode),
    .wdt_fed(st_r.wdt_fed),
    .bod_int(bod_int),
    .bod_rst(bod_rst),
    .wdt_int(wdt_int),
    .wkt_int(wkt_int),
    .wkt_lp_clk(st_r.lp_en & st_r.wkt_sel & (st_r.wkt_cnt != 32'h0000_0000)),
    .ser_int(ser_int),
    .ser_slave_ext_clk(ser_slave_ext_clk),
    .wake_pin_n(wake_pin_n),
    .wake_pin_en(st_r.wake_pin_en),
    .wake(wake),
    .wake_reset(wake_reset)
  );

  function automatic logic [11:0] word_addr(input logic [11:0] a);
    word_addr = {a[11:2], 2'b00};
  endfunction : word_addr

  always_comb begin
    st_nxt = st_r;
    setup = psel & ~penable;
    st_nxt.pready = setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    st_nxt.wake_rst = 1'b0;
    if (setup) begin
      unique case (word_addr(paddr))
        `OFS_PWR_CTRL: begin
          st_nxt.prdata = {26'h0, st_r.lock, 2'b00, st_r.mode};
          if (pwrite) begin
            st_nxt.lock = st_r.lock | pwdata[`CTRL_LOCK_BIT];
            if (pwdata[`CTRL_GO_BIT]) begin
              if (pwdata[`CTRL_MODE_LSB +: 3] == MODE_DEEP_PD) begin
                if (!(st_r.lock | pwdata[`CTRL_LOCK_BIT])) begin
                  st_nxt.mode = MODE_DEEP_PD;
                end
              end else if (pwdata[`CTRL_MODE_LSB +: 3] <= MODE_POWER_DOWN) begin
                st_nxt.mode = pwr_mode_t'(pwdata[`CTRL_MODE_LSB +: 3]);
              end
            end
          end
        end
        `OFS_PWR_STATUS: st_nxt.prdata = {27'h0, st_r.dpd_woken, st_r.core_clk_en, st_r.mode};
        `OFS_PIN_ENABLE: begin
          st_nxt.prdata = {24'h0, st_r.pin_en};
          if (pwrite) st_nxt.pin_en = pwdata[7:0];
        end
        `OFS_PERIPH_ENABLE: begin
          st_nxt.prdata = {28'h0, st_r.per_en};
          if (pwrite) st_nxt.per_en = pwdata[3:0];
        end
        `OFS_SLEEP_CFG: begin
          st_nxt.prdata = {24'h0, st_r.sleep_cfg};
          if (pwrite) st_nxt.sleep_cfg = pwdata[7:0];
        end
        `OFS_BROWNOUT_CTRL: begin
          st_nxt.prdata = {24'h0, st_r.bod_ctrl};
          if (pwrite) st_nxt.bod_ctrl = pwdata[7:0];
        end
        `OFS_WDT_MODE: begin
          st_nxt.prdata = {24'h0, st_r.wdt_mode};
          if (pwrite) begin
            st_nxt.wdt_mode = pwdata[7:0];
            st_nxt.wdt_fed = st_r.wdt_fed | pwdata[`WDT_FEED_BIT];
          end
        end
        `OFS_WAKE_PIN_EN: begin
          st_nxt.prdata = {24'h0, st_r.wake_pin_en};
          if (pwrite) st_nxt.wake_pin_en = pwdata[7:0];
        end
        `OFS_OSC_CTRL: begin
          st_nxt.prdata = {28'h0, lposc_ready, st_r.wkt_sel, st_r.lp_sel, st_r.lp_en};
          if (pwrite) begin
            st_nxt.lp_en = pwdata[`OSC_LPEN_BIT];
            st_nxt.wkt_sel = pwdata[`OSC_WKTSEL_BIT];
            // switching only once the oscillator reports stable
            st_nxt.lp_sel = pwdata[`OSC_LPSEL_BIT] & pwdata[`OSC_LPEN_BIT]
                            & lposc_ready;
          end
        end
        `OFS_WAKE_TIMER: begin
          st_nxt.prdata = st_r.wkt_cnt;
          if (pwrite) st_nxt.wkt_cnt = pwdata;
        end
        `OFS_NESTED_INTERRUPT_CTRL_EN: begin
          st_nxt.prdata = st_r.nested_interrupt_ctrl_en;
          if (pwrite) st_nxt.nested_interrupt_ctrl_en = pwdata;
        end
        default: begin
          if (word_addr(paddr) >= `OFS_GPREG0
              && word_addr(paddr) < `OFS_GPREG0 + 12'(`GPREG_NUM * 4)) begin
            st_nxt.prdata = st_r.gpreg[32*(3'(paddr[4:2]))+:32];
            if (pwrite) st_nxt.gpreg[32*(3'(paddr[4:2]))+:32] = pwdata;
          end else begin
            st_nxt.pslverr = 1'b1;
          end
        end
      endcase
    end
    if (!st_r.lp_en) st_nxt.lp_sel = 1'b0;
    // timer counts down only while the low-power osc enable and timer select bits are set
    if (st_r.wkt_cnt != 32'h0000_0000 && st_r.lp_en && st_r.wkt_sel
        && !(setup && pwrite && word_addr(paddr) == `OFS_WAKE_TIMER)) begin
      st_nxt.wkt_cnt = st_r.wkt_cnt - 32'h0000_0001;
    end
    if (st_r.mode != MODE_RUN && (wake | wake_reset)) begin
      st_nxt.mode = MODE_RUN;
      st_nxt.wake_rst = wake_reset;
      if (st_r.mode == MODE_DEEP_PD) begin
        st_nxt.dpd_woken = 1'b1;
        st_nxt.lp_sel = 1'b0;
      end
    end
    st_nxt.core_clk_en = (st_nxt.mode == MODE_RUN);
    st_nxt.main_pwr_on = (st_nxt.mode != MODE_DEEP_PD);
    st_nxt.fro_on = 1'b1;
    st_nxt.fro_out_en = 1'b1;
    st_nxt.flash_on = 1'b1;
    st_nxt.flash_standby = 1'b0;
    st_nxt.periph_on = 1'b1;
    st_nxt.adc_on = 1'b1;
    st_nxt.bod_on = 1'b1;
    st_nxt.lposc_on = st_nxt.lp_en;
    unique case (st_nxt.mode)
      MODE_DEEP_SLEEP: begin
        st_nxt.fro_out_en = 1'b0;
        st_nxt.flash_standby = 1'b1;
        st_nxt.periph_on = 1'b0;
        st_nxt.adc_on = 1'b0;
        st_nxt.bod_on = st_nxt.sleep_cfg[`SCFG_BOD_BIT];
        st_nxt.lposc_on = st_nxt.sleep_cfg[`SCFG_LPOSC_BIT];
      end
      MODE_POWER_DOWN: begin
        st_nxt.fro_on = 1'b0;
        st_nxt.fro_out_en = 1'b0;
        st_nxt.flash_on = 1'b0;
        st_nxt.periph_on = 1'b0;
        st_nxt.adc_on = 1'b0;
        st_nxt.bod_on = st_nxt.sleep_cfg[`SCFG_BOD_BIT];
        st_nxt.lposc_on = st_nxt.sleep_cfg[`SCFG_LPOSC_BIT];
      end
      MODE_DEEP_PD: begin
        st_nxt.fro_on = 1'b0;
        st_nxt.fro_out_en = 1'b0;
        st_nxt.flash_on = 1'b0;
        st_nxt.periph_on = 1'b0;
        st_nxt.adc_on = 1'b0;
        st_nxt.bod_on = 1'b0;
        st_nxt.lposc_on = 1'b0;
      end
      default: begin
        st_nxt.lposc_on = st_nxt.lp_en;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.sleep_cfg <= 8'(`RST_SLEEP_CFG);
      st_r.core_clk_en <= 1'b1;
      st_r.fro_on <= 1'b1;
      st_r.fro_out_en <= 1'b1;
      st_r.flash_on <= 1'b1;
      st_r.periph_on <= 1'b1;
      st_r.adc_on <= 1'b1;
      st_r.bod_on <= 1'b1;
      st_r.main_pwr_on <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign core_clk_en = st_r.core_clk_en;
  assign fro_on = st_r.fro_on;
  assign fro_out_en = st_r.fro_out_en;
  assign flash_on = st_r.flash_on;
  assign flash_standby = st_r.flash_standby;
  assign periph_on = st_r.periph_on;
  assign adc_on = st_r.adc_on;
  assign bod_on = st_r.bod_on;
  assign lposc_on = st_r.lposc_on;
  assign main_pwr_on = st_r.main_pwr_on;
  assign wake_reset_req = st_r.wake_rst;
  assign clk_sel_lposc = st_r.lp_sel;
  assign wkt_count = st_r.wkt_cnt;
endmodule : pwr_mode_ctrl

//--- verif/pwr_mode_checker.sv
// port assertions of the power-mode controller
`timescale 1ns/1ps
module pwr_mode_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] wake_pin_n,
  input wire logic lposc_ready,
  input wire logic core_clk_en,
  input wire logic fro_on,
  input wire logic fro_out_en,
  input wire logic flash_on,
  input wire logic flash_standby,
  input wire logic periph_on,
  input wire logic adc_on,
  input wire logic bod_on,
  input wire logic lposc_on,
  input wire logic main_pwr_on,
  input wire logic wake_reset_req,
  input wire logic clk_sel_lposc
);
  typedef struct packed {logic lock; logic [7:0] wpen;} chk_st_t;
  chk_st_t st_r;
  chk_st_t st_nxt;
  logic wr_ctl;
  // bus-side copies, since the checker has no view of the registers
  assign wr_ctl = psel && !penable && pwrite && paddr == 12'h000;
  always_comb begin
    st_nxt = st_r;
    if (wr_ctl && pwdata[5]) st_nxt.lock = 1'b1;
    if (psel && !penable && pwrite && paddr == 12'h01c) st_nxt.wpen = pwdata[7:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= '0;
    else st_r <= st_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence setup_s; psel && !penable; endsequence
  sequence dpd_req_s; wr_ctl && pwdata[5:0] == 6'h14; endsequence
  AST_APB_ONE_WAIT: assert property (setup_s |=> penable && pready) else $error("pready late");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_DPD_ALL_OFF: assert property (!main_pwr_on |-> !(fro_on || fro_out_en || flash_on
    || periph_on || adc_on || bod_on || lposc_on || core_clk_en)) else $error("dpd leak");
  AST_DS_GATES: assert property (fro_on && !fro_out_en |-> flash_standby
    && !periph_on && !adc_on) else $error("deep-sleep gating");
  AST_SLEEP_ENTRY: assert property (wr_ctl && pwdata[5:0] == 6'h11 |-> ##2
    !core_clk_en && periph_on) else $error("sleep entry");
  AST_DPD_ENTRY: assert property (dpd_req_s ##0 !st_r.lock |-> ##2 !main_pwr_on)
    else $error("dpd entry");
  AST_DPD_LOCKED: assert property (dpd_req_s ##0 st_r.lock |=> main_pwr_on [*3])
    else $error("dpd not refused");
  AST_PIN_WAKES: assert property (!main_pwr_on && |(~wake_pin_n & st_r.wpen)
    |-> ##[1:3] main_pwr_on) else $error("pin wake");
  AST_RST_PULSE: assert property (wake_reset_req |=> !wake_reset_req)
    else $error("reset pulse long");
  AST_CLK_SWITCH: assert property ($rose(clk_sel_lposc) |-> lposc_on
    && $past(lposc_ready)) else $error("early switch");
endmodule : pwr_mode_checker
bind pwr_mode_ctrl pwr_mode_checker u_pwr_mode_checker (.*);

//--- verif/wake_src_model.sv
// wake sources and wake pins facing the power-mode controller
`timescale 1ns/1ps
`include "pwr_params.svh"
module wake_src_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lposc_on,
  input wire logic [7:0] req_pin,
  input wire logic [4:0] req_ev,
  input wire logic [7:0] req_wake,
  output logic [7:0] pin_irq,
  output logic bod_int,
  output logic bod_rst,
  output logic wdt_int,
  output logic wkt_int,
  output logic ser_int,
  output logic ser_slave_ext_clk,
  output logic lposc_ready,
  output logic [7:0] wake_pin_n
);
  typedef struct packed {logic [7:0] pin; logic [4:0] ev; logic [7:0] wk; logic [15:0] cnt;} src_t;
  src_t st_r;
  src_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin = req_pin;
    st_nxt.ev = req_ev;
    st_nxt.wk = req_wake;
    // oscillator only counts as stable a settle span after its enable
    if (!lposc_on) st_nxt.cnt = 16'h0000;
    else if (!lposc_ready) st_nxt.cnt = st_r.cnt + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= '0;
    else st_r <= st_nxt;
  end
  assign pin_irq = st_r.pin;
  assign {ser_int, wkt_int, wdt_int, bod_rst, bod_int} = st_r.ev;
  assign ser_slave_ext_clk = st_r.ev[4];
  assign lposc_ready = st_r.cnt == `LPOSC_SETTLE_CYC;
  // released wake pins sit at the pull-up level
  assign wake_pin_n = ~st_r.wk;
endmodule : wake_src_model

//--- verif/tb_pwr_mode_ctrl.sv
// testbench of the power-mode controller
`timescale 1ns/1ps
module tb_pwr_mode_ctrl;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, irq_pend, wkt_count, rd_q;
  logic [7:0] pin_irq, wake_pin_n, req_pin, req_wake;
  logic [4:0] req_ev;
  logic bod_int, bod_rst, wdt_int, wkt_int, ser_int, ser_slave_ext_clk, lposc_ready;
  logic core_clk_en, fro_on, fro_out_en, flash_on, flash_standby, periph_on, adc_on;
  logic bod_on, lposc_on, main_pwr_on, wake_reset_req, clk_sel_lposc;
  logic [6:0] outs;
  int err_count = 0;
  int samples_checked = 0;
  assign outs = {core_clk_en, fro_on, fro_out_en, flash_standby, periph_on, adc_on, main_pwr_on};
  pwr_mode_ctrl u_pwr_mode_ctrl (.*);
  wake_src_model u_wake_src_model (.*);
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a missing answer
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(a, 1'b0, 32'h0000_0000);
    chk("read data", e, rd_q);
    chk("slave error", 32'(ee), 32'(err_q));
  endtask : rd
  task automatic idle_chk;
    repeat (10) @(posedge clk);
    chk("core clock held off", 32'h0, 32'(core_clk_en));
  endtask : idle_chk
  task automatic wait_wake;
    for (int n = 0; n < 20 && core_clk_en !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    chk("run outputs", 32'h77, 32'(outs));
  endtask : wait_wake
  task automatic src_wake(input logic [31:0] pe, input logic [31:0] ne, input logic [31:0] m,
                          input logic [4:0] ev, input logic rs);
    apb(12'h00c, 1'b1, pe);
    apb(12'h028, 1'b1, ne);
    apb(12'h000, 1'b1, m);
    req_ev <= ev;
    for (int n = 0; n < 20 && core_clk_en !== 1'b1; n++) @(posedge clk);
    chk("reset wake pulse", 32'(rs), 32'(wake_reset_req));
    req_ev <= '0;
    @(posedge clk);
    chk("run outputs", 32'h77, 32'(outs));
  endtask : src_wake
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    #100_000;
    err_count++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, irq_pend, req_pin, req_ev, req_wake} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset outputs", 32'h77, 32'(outs));
    rd(12'hffc, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 5; i++) apb(12'h040 + 12'(4 * i), 1'b1, 32'h5a5a_0000 + i);
    apb(12'h028, 1'b1, 32'h0000_0105);
    apb(12'h000, 1'b1, 32'h0000_0011);
    chk("sleep outputs", 32'h37, 32'(outs));
    irq_pend <= 32'h0000_0002;
    idle_chk();
    irq_pend <= 32'h0000_0001;
    wait_wake();
    irq_pend <= '0;
    apb(12'h008, 1'b1, 32'h0000_0004);
    apb(12'h01c, 1'b1, 32'h0000_0080);
    apb(12'h000, 1'b1, 32'h0000_0012);
    chk("deep-sleep outputs", 32'h29, 32'(outs));
    req_wake <= 8'h80;
    idle_chk();
    req_wake <= '0;
    req_pin <= 8'h04;
    wait_wake();
    req_pin <= '0;
    apb(12'h00c, 1'b1, 32'h0000_0001);
    apb(12'h014, 1'b1, 32'h0000_0001);
    apb(12'h010, 1'b1, 32'h0000_0003);
    apb(12'h000, 1'b1, 32'h0000_0013);
    chk("power-down outputs", 32'h01, 32'(outs));
    chk("flash off", 32'h0, 32'(flash_on));
    chk("detector powered", 32'h1, 32'(bod_on));
    chk("lposc powered", 32'h1, 32'(lposc_on));
    req_ev <= 5'h01;
    wait_wake();
    req_ev <= '0;
    // the watchdog only counts as running once it has been fed
    apb(12'h018, 1'b1, 32'h0000_000d);
    apb(12'h000, 1'b1, 32'h0000_0012);
    req_ev <= 5'h04;
    for (int n = 0; n < 20 && wake_reset_req !== 1'b1; n++) @(posedge clk);
    chk("reset wake pulse", 32'h1, 32'(wake_reset_req));
    req_ev <= '0;
    wait_wake();
    apb(12'h014, 1'b1, 32'h0000_0002);
    src_wake(32'h0000_0001, 32'h0000_0105, 32'h0000_0013, 5'h02, 1'b1);
    apb(12'h018, 1'b1, 32'h0000_000b);
    apb(12'h00c, 1'b1, 32'h0000_0002);
    apb(12'h000, 1'b1, 32'h0000_0012);
    req_ev <= 5'h04;
    idle_chk();
    apb(12'h028, 1'b1, 32'h0000_0305);
    wait_wake();
    req_ev <= '0;
    src_wake(32'h0000_0008, 32'h0000_0805, 32'h0000_0012, 5'h10, 1'b0);
    apb(12'h000, 1'b1, 32'h0000_0014);
    chk("deep power-down outputs", 32'h0, 32'(outs));
    req_wake <= 8'h80;
    wait_wake();
    req_wake <= '0;
    rd(12'h004, 32'h0000_0018, 1'b0);
    for (int i = 0; i < 5; i++) rd(12'h040 + 12'(4 * i), 32'h5a5a_0000 + i, 1'b0);
    apb(12'h020, 1'b1, 32'h0000_0003);
    chk("unsettled select", 32'h0, 32'(clk_sel_lposc));
    for (int n = 0; n < 200 && lposc_ready !== 1'b1; n++) @(posedge clk);
    apb(12'h020, 1'b1, 32'h0000_0003);
    chk("settled select", 32'h1, 32'(clk_sel_lposc));
    apb(12'h020, 1'b1, 32'h0000_0007);
    apb(12'h024, 1'b1, 32'h0000_1000);
    // one count lost per clock since the write edge
    chk("timer count", 32'h0000_0fff, wkt_count);
    src_wake(32'h0000_0004, 32'h0000_0405, 32'h0000_0013, 5'h08, 1'b0);
    apb(12'h000, 1'b1, 32'h0000_0020);
    apb(12'h000, 1'b1, 32'h0000_0014);
    chk("locked entry", 32'h77, 32'(outs));
    give_verdict();
  end
endmodule : tb_pwr_mode_ctrl
